//--- viu_top.sv
// Vectored interrupt unit: flags, enables, priorities, arbitration and APB slave
`timescale 1ns/10ps
`default_nettype none
`include "viu_regs.svh"
module viu_top
  import viu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External interrupt pins, active low
  input wire logic [5:0] ext_pin_n,
  // Peripheral event pulses
  input wire logic power_fail_set,
  input wire logic timer0_ovf_set,
  input wire logic timer1_ovf_set,
  input wire logic timer2_ovf_set,
  input wire logic timer2_second_set,
  input wire logic [2:0] compare_set,
  input wire logic [3:0] capture_set,
  input wire logic serial0_rx_set,
  input wire logic serial0_tx_set,
  input wire logic serial1_rx_set,
  input wire logic serial1_tx_set,
  input wire logic converter_done_set,
  // CPU core handshake
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [3:0] irq_source,
  output logic irq_level,
  input wire logic irq_ack,
  input wire logic irq_return
);
  // Register state
  logic [7:0] timer_ctrl_q;
  logic [7:0] timer_ctrl_d;
  logic [7:0] enable_q;
  logic [7:0] priority_q;
  logic [7:0] extended_enable_reg_q;
  logic [7:0] extended_priority_reg_q;
  logic [7:0] timer_two_irq_reg_q;
  logic [7:0] timer_two_irq_reg_d;
  logic [7:0] watchdog_control_reg_q;
  logic [7:0] watchdog_control_reg_d;
  logic [7:0] periph_flags_q;
  logic [7:0] periph_flags_d;

  // Handshake state
  viu_state_t state_q;
  logic req_q;
  logic lvl_q;
  viu_src_t idx_q;
  logic [7:0] vec_q;
  logic [1:0] in_service_q;

  // APB state
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Pin path
  logic [5:0] pin_sync;
  logic [5:0] pin_prev_q;
  logic [5:0] pin_fall;

  // Arbitration
  viu_vec16_t req_vec;
  viu_vec16_t high_vec;
  logic arb_valid;
  viu_src_t arb_idx;
  logic arb_lvl;
  logic grant;
  logic [15:0] grant_onehot;

  // Bus decode
  logic acc;
  logic wr;
  logic rd_phase;
  logic mapped;
  logic wr_tc;
  logic wr_en;
  logic wr_pr;
  logic wr_xen;
  logic wr_xpr;
  logic wr_t2;
  logic wr_wd;
  logic wr_pf;
  logic [31:0] rd_data;
  logic [7:0] wb;

  function automatic logic [7:0] vec_of(input viu_src_t i);
    if (i == `VIU_PFAIL_IDX) begin
      vec_of = `VIU_PFAIL_VEC;
    end else if (i >= `VIU_SKIP_IDX) begin
      vec_of = `VIU_VEC_BASE + {1'b0, i, 3'b000};
    end else begin
      vec_of = `VIU_VEC_BASE + {1'b0, i - 4'h1, 3'b000};
    end
  endfunction : vec_of

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_req = req_q;
  assign irq_vector = vec_q;
  assign irq_source = idx_q;
  assign irq_level = lvl_q;

  // Pins pass two flops before edge detection
  viu_sync #(.WIDTH(`VIU_NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ext_pin_n),
    .sync_out(pin_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q <= 6'h3F;
    end else begin
      pin_prev_q <= pin_sync;
    end
  end

  assign pin_fall = pin_prev_q & ~pin_sync;

  // APB: one wait state, write and read complete at the pready edge
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;
  assign rd_phase = psel & penable & ~pready_q;
  assign wb = pwdata[7:0];

  always_comb begin
    mapped = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr == `VIU_OFS_TIMER_CTRL) begin
      rd_data = {24'h00_0000, timer_ctrl_q};
    end else if (paddr == `VIU_OFS_ENABLE) begin
      rd_data = {24'h00_0000, enable_q};
    end else if (paddr == `VIU_OFS_PRIORITY) begin
      rd_data = {24'h00_0000, priority_q};
    end else if (paddr == `VIU_OFS_EXT_ENABLE) begin
      rd_data = {24'h00_0000, extended_enable_reg_q};
    end else if (paddr == `VIU_OFS_EXT_PRIORITY) begin
      rd_data = {24'h00_0000, extended_priority_reg_q};
    end else if (paddr == `VIU_OFS_TIMER_TWO_IRQ) begin
      rd_data = {24'h00_0000, timer_two_irq_reg_q};
    end else if (paddr == `VIU_OFS_WATCHDOG_CTRL) begin
      rd_data = {24'h00_0000, watchdog_control_reg_q};
    end else if (paddr == `VIU_OFS_PERIPH_FLAGS) begin
      rd_data = {24'h00_0000, periph_flags_q};
    end else if (paddr == `VIU_OFS_STATUS) begin
      rd_data = {16'h0000, in_service_q, lvl_q, req_q, idx_q, vec_q};
    end else begin
      mapped = 1'b0;
    end
  end

  assign wr_tc = wr & (paddr == `VIU_OFS_TIMER_CTRL);
  assign wr_en = wr & (paddr == `VIU_OFS_ENABLE);
  assign wr_pr = wr & (paddr == `VIU_OFS_PRIORITY);
  assign wr_xen = wr & (paddr == `VIU_OFS_EXT_ENABLE);
  assign wr_xpr = wr & (paddr == `VIU_OFS_EXT_PRIORITY);
  assign wr_t2 = wr & (paddr == `VIU_OFS_TIMER_TWO_IRQ);
  assign wr_wd = wr & (paddr == `VIU_OFS_WATCHDOG_CTRL);
  assign wr_pf = wr & (paddr == `VIU_OFS_PERIPH_FLAGS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= rd_phase;
      pslverr_q <= rd_phase & ~mapped;
      if (rd_phase & ~pwrite) begin
        prdata_q <= rd_data;
      end
    end
  end

  // Enable and priority registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= `VIU_RST_BYTE;
      priority_q <= `VIU_RST_BYTE;
      extended_enable_reg_q <= `VIU_RST_BYTE;
      extended_priority_reg_q <= `VIU_RST_BYTE;
    end else begin
      if (wr_en) begin
        enable_q <= wb & `VIU_MASK_ENABLE;
      end
      if (wr_pr) begin
        priority_q <= wb & `VIU_MASK_ENABLE;
      end
      if (wr_xen) begin
        extended_enable_reg_q <= wb & `VIU_MASK_EXT;
      end
      if (wr_xpr) begin
        extended_priority_reg_q <= wb & `VIU_MASK_EXT;
      end
    end
  end

  assign grant = irq_ack & req_q;
  assign grant_onehot = grant ? (16'h0001 << idx_q) : 16'h0000;

  // Timer control flags; hardware set wins over software clear
  always_comb begin
    timer_ctrl_d = wr_tc ? wb : timer_ctrl_q;
    if (grant_onehot[4]) begin
      timer_ctrl_d[`VIU_TC_T0_OVF] = 1'b0;
    end
    if (grant_onehot[10]) begin
      timer_ctrl_d[`VIU_TC_T1_OVF] = 1'b0;
    end
    if (grant_onehot[1] & timer_ctrl_q[`VIU_TC_EXT0_MODE]) begin
      timer_ctrl_d[`VIU_TC_EXT0_FLAG] = 1'b0;
    end
    if (grant_onehot[7] & timer_ctrl_q[`VIU_TC_EXT1_MODE]) begin
      timer_ctrl_d[`VIU_TC_EXT1_FLAG] = 1'b0;
    end
    if (timer0_ovf_set) begin
      timer_ctrl_d[`VIU_TC_T0_OVF] = 1'b1;
    end
    if (timer1_ovf_set) begin
      timer_ctrl_d[`VIU_TC_T1_OVF] = 1'b1;
    end
    if (timer_ctrl_q[`VIU_TC_EXT0_MODE]) begin
      timer_ctrl_d[`VIU_TC_EXT0_FLAG] = timer_ctrl_d[`VIU_TC_EXT0_FLAG] | pin_fall[0];
    end else begin
      timer_ctrl_d[`VIU_TC_EXT0_FLAG] = ~pin_sync[0];
    end
    if (timer_ctrl_q[`VIU_TC_EXT1_MODE]) begin
      timer_ctrl_d[`VIU_TC_EXT1_FLAG] = timer_ctrl_d[`VIU_TC_EXT1_FLAG] | pin_fall[1];
    end else begin
      timer_ctrl_d[`VIU_TC_EXT1_FLAG] = ~pin_sync[1];
    end
    timer_ctrl_d = timer_ctrl_d & `VIU_MASK_TIMER_CTRL;
  end

  // Remaining flags clear only by software write
  always_comb begin
    timer_two_irq_reg_d = wr_t2 ? wb : timer_two_irq_reg_q;
    timer_two_irq_reg_d[`VIU_T2_SHARED_LSB +: 4] = timer_two_irq_reg_d[`VIU_T2_SHARED_LSB +: 4]
      | capture_set | pin_fall[5:2];
    timer_two_irq_reg_d[`VIU_T2_CM0] = timer_two_irq_reg_d[`VIU_T2_CM0] | compare_set[0];
    timer_two_irq_reg_d[`VIU_T2_CM1] = timer_two_irq_reg_d[`VIU_T2_CM1] | compare_set[1];
    timer_two_irq_reg_d[`VIU_T2_CM2] = timer_two_irq_reg_d[`VIU_T2_CM2] | compare_set[2];
    timer_two_irq_reg_d = timer_two_irq_reg_d & `VIU_MASK_TIMER_TWO;

    watchdog_control_reg_d = wr_wd ? wb : watchdog_control_reg_q;
    watchdog_control_reg_d[`VIU_WD_PFAIL_FLAG] = watchdog_control_reg_d[`VIU_WD_PFAIL_FLAG]
      | power_fail_set;
    watchdog_control_reg_d = watchdog_control_reg_d & `VIU_MASK_WATCHDOG;

    periph_flags_d = wr_pf ? wb : periph_flags_q;
    periph_flags_d[`VIU_PF_S0_RX] = periph_flags_d[`VIU_PF_S0_RX] | serial0_rx_set;
    periph_flags_d[`VIU_PF_S0_TX] = periph_flags_d[`VIU_PF_S0_TX] | serial0_tx_set;
    periph_flags_d[`VIU_PF_S1_RX] = periph_flags_d[`VIU_PF_S1_RX] | serial1_rx_set;
    periph_flags_d[`VIU_PF_S1_TX] = periph_flags_d[`VIU_PF_S1_TX] | serial1_tx_set;
    periph_flags_d[`VIU_PF_CONV] = periph_flags_d[`VIU_PF_CONV] | converter_done_set;
    periph_flags_d[`VIU_PF_T2_OVF] = periph_flags_d[`VIU_PF_T2_OVF] | timer2_ovf_set;
    periph_flags_d[`VIU_PF_T2_SECOND] = periph_flags_d[`VIU_PF_T2_SECOND] | timer2_second_set;
    periph_flags_d = periph_flags_d & `VIU_MASK_PERIPH;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctrl_q <= `VIU_RST_BYTE;
      timer_two_irq_reg_q <= `VIU_RST_BYTE;
      watchdog_control_reg_q <= `VIU_RST_BYTE;
      periph_flags_q <= `VIU_RST_BYTE;
    end else begin
      timer_ctrl_q <= timer_ctrl_d;
      timer_two_irq_reg_q <= timer_two_irq_reg_d;
      watchdog_control_reg_q <= watchdog_control_reg_d;
      periph_flags_q <= periph_flags_d;
    end
  end

  // Source table; index equals natural priority
  always_comb begin
    req_vec[0] = watchdog_control_reg_q[`VIU_WD_PFAIL_FLAG]
      & watchdog_control_reg_q[`VIU_WD_PFAIL_EN];
    high_vec[0] = 1'b1;
    req_vec[1] = timer_ctrl_q[`VIU_TC_EXT0_FLAG] & enable_q[`VIU_EN_EXT0];
    high_vec[1] = priority_q[`VIU_EN_EXT0];
    req_vec[2] = (periph_flags_q[`VIU_PF_S1_RX] | periph_flags_q[`VIU_PF_S1_TX])
      & enable_q[`VIU_EN_S1];
    high_vec[2] = priority_q[`VIU_EN_S1];
    req_vec[3] = periph_flags_q[`VIU_PF_CONV] & enable_q[`VIU_EN_CONV];
    high_vec[3] = priority_q[`VIU_EN_CONV];
    req_vec[4] = timer_ctrl_q[`VIU_TC_T0_OVF] & enable_q[`VIU_EN_T0];
    high_vec[4] = priority_q[`VIU_EN_T0];
    req_vec[5] = timer_two_irq_reg_q[`VIU_T2_SHARED_LSB] & extended_enable_reg_q[`VIU_T2_SHARED_LSB];
    high_vec[5] = extended_priority_reg_q[`VIU_T2_SHARED_LSB];
    req_vec[6] = timer_two_irq_reg_q[`VIU_T2_CM0] & extended_enable_reg_q[`VIU_XEN_CM0];
    high_vec[6] = extended_priority_reg_q[`VIU_XEN_CM0];
    req_vec[7] = timer_ctrl_q[`VIU_TC_EXT1_FLAG] & enable_q[`VIU_EN_EXT1];
    high_vec[7] = priority_q[`VIU_EN_EXT1];
    req_vec[8] = timer_two_irq_reg_q[`VIU_T2_SHARED_LSB + 1] & extended_enable_reg_q[`VIU_T2_SHARED_LSB + 1];
    high_vec[8] = extended_priority_reg_q[`VIU_T2_SHARED_LSB + 1];
    req_vec[9] = timer_two_irq_reg_q[`VIU_T2_CM1] & extended_enable_reg_q[`VIU_XEN_CM1];
    high_vec[9] = extended_priority_reg_q[`VIU_XEN_CM1];
    req_vec[10] = timer_ctrl_q[`VIU_TC_T1_OVF] & enable_q[`VIU_EN_T1];
    high_vec[10] = priority_q[`VIU_EN_T1];
    req_vec[11] = timer_two_irq_reg_q[`VIU_T2_SHARED_LSB + 2] & extended_enable_reg_q[`VIU_T2_SHARED_LSB + 2];
    high_vec[11] = extended_priority_reg_q[`VIU_T2_SHARED_LSB + 2];
    req_vec[12] = timer_two_irq_reg_q[`VIU_T2_CM2] & extended_enable_reg_q[`VIU_XEN_CM2];
    high_vec[12] = extended_priority_reg_q[`VIU_XEN_CM2];
    req_vec[13] = (periph_flags_q[`VIU_PF_S0_RX] | periph_flags_q[`VIU_PF_S0_TX])
      & enable_q[`VIU_EN_S0];
    high_vec[13] = priority_q[`VIU_EN_S0];
    req_vec[14] = timer_two_irq_reg_q[`VIU_T2_SHARED_LSB + 3] & extended_enable_reg_q[`VIU_T2_SHARED_LSB + 3];
    high_vec[14] = extended_priority_reg_q[`VIU_T2_SHARED_LSB + 3];
    req_vec[15] = (periph_flags_q[`VIU_PF_T2_OVF] | periph_flags_q[`VIU_PF_T2_SECOND])
      & extended_enable_reg_q[`VIU_XEN_T2];
    high_vec[15] = extended_priority_reg_q[`VIU_XEN_T2];
  end

  // A high service blocks all; a low service blocks only low requests
  viu_arbiter u_arb (
    .req(req_vec),
    .high_lvl(high_vec),
    .allow_high(~in_service_q[1]),
    .allow_low(in_service_q == 2'b00),
    .valid(arb_valid),
    .idx(arb_idx),
    .lvl(arb_lvl)
  );

  // Offer to the core; one settle cycle after a grant lets cleared flags land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= VIU_RUN;
      req_q <= 1'b0;
      lvl_q <= 1'b0;
      idx_q <= '0;
      vec_q <= 8'h00;
    end else begin
      case (state_q)
        VIU_RUN: begin
          if (grant) begin
            state_q <= VIU_SETTLE;
            req_q <= 1'b0;
          end else begin
            req_q <= arb_valid;
            if (arb_valid) begin
              lvl_q <= arb_lvl;
              idx_q <= arb_idx;
              vec_q <= vec_of(arb_idx);
            end
          end
        end
        VIU_SETTLE: begin
          state_q <= VIU_RUN;
          req_q <= 1'b0;
        end
        default: begin
          state_q <= VIU_RUN;
          req_q <= 1'b0;
        end
      endcase
    end
  end

  // In-service levels; a return ends the highest active level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_service_q <= 2'b00;
    end else if (grant) begin
      if (lvl_q) begin
        in_service_q[1] <= 1'b1;
      end else begin
        in_service_q[0] <= 1'b1;
      end
    end else if (irq_return) begin
      if (in_service_q[1]) begin
        in_service_q[1] <= 1'b0;
      end else begin
        in_service_q[0] <= 1'b0;
      end
    end
  end
endmodule : viu_top
`default_nettype wire

//--- viu_regs.svh
// Register offsets, field positions and constants of the vectored interrupt unit
`ifndef VIU_REGS_SVH
`define VIU_REGS_SVH

// Register byte offsets
`define VIU_OFS_TIMER_CTRL 12'h000
`define VIU_OFS_ENABLE 12'h004
`define VIU_OFS_PRIORITY 12'h008
`define VIU_OFS_EXT_ENABLE 12'h00C
`define VIU_OFS_EXT_PRIORITY 12'h010
`define VIU_OFS_TIMER_TWO_IRQ 12'h014
`define VIU_OFS_WATCHDOG_CTRL 12'h018
`define VIU_OFS_PERIPH_FLAGS 12'h01C
`define VIU_OFS_STATUS 12'h020

// Writable masks and reset values
`define VIU_MASK_TIMER_CTRL 8'hAF
`define VIU_MASK_ENABLE 8'h7F
`define VIU_MASK_EXT 8'hFF
`define VIU_MASK_TIMER_TWO 8'h7F
`define VIU_MASK_WATCHDOG 8'h30
`define VIU_MASK_PERIPH 8'h7F
`define VIU_RST_BYTE 8'h00

// Timer control fields
`define VIU_TC_EXT0_MODE 0
`define VIU_TC_EXT0_FLAG 1
`define VIU_TC_EXT1_MODE 2
`define VIU_TC_EXT1_FLAG 3
`define VIU_TC_T0_OVF 5
`define VIU_TC_T1_OVF 7

// Watchdog control fields
`define VIU_WD_PFAIL_FLAG 4
`define VIU_WD_PFAIL_EN 5

// Peripheral flag fields
`define VIU_PF_S0_RX 0
`define VIU_PF_S0_TX 1
`define VIU_PF_S1_RX 2
`define VIU_PF_S1_TX 3
`define VIU_PF_CONV 4
`define VIU_PF_T2_OVF 5
`define VIU_PF_T2_SECOND 6

// Timer-two flag register fields
`define VIU_T2_SHARED_LSB 0
`define VIU_T2_CM0 4
`define VIU_T2_CM1 5
`define VIU_T2_CM2 6

// Enable / priority fields
`define VIU_EN_EXT0 0
`define VIU_EN_T0 1
`define VIU_EN_EXT1 2
`define VIU_EN_T1 3
`define VIU_EN_S0 4
`define VIU_EN_S1 5
`define VIU_EN_CONV 6
`define VIU_XEN_CM0 4
`define VIU_XEN_CM1 5
`define VIU_XEN_CM2 6
`define VIU_XEN_T2 7

// Vector generation
`define VIU_PFAIL_IDX 4'h0
`define VIU_PFAIL_VEC 8'h33
`define VIU_VEC_BASE 8'h03
`define VIU_SKIP_IDX 4'h7
`define VIU_NSRC 16
`define VIU_NPIN 6

`endif

//--- viu_pkg.sv
// Types shared by the vectored interrupt unit
package viu_pkg;
  typedef enum logic [0:0] {VIU_RUN, VIU_SETTLE} viu_state_t;
  typedef logic [3:0] viu_src_t;
  typedef logic [15:0] viu_vec16_t;
endpackage : viu_pkg

//--- viu_sync.sv
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module viu_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // Reset value matches an idle high pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= async_in[g];
          sync_q <= meta_q;
        end
      end
      assign sync_out[g] = sync_q;
    end
  endgenerate
endmodule : viu_sync
`default_nettype wire

//--- viu_arbiter.sv
// Two-level fixed-priority request selector
`timescale 1ns/10ps
`default_nettype none
`include "viu_regs.svh"
module viu_arbiter
  import viu_pkg::*;
(
  // Requests and their programmed levels
  input wire logic [15:0] req,
  input wire logic [15:0] high_lvl,
  // Which levels may be granted now
  input wire logic allow_high,
  input wire logic allow_low,
  // Selection
  output logic valid,
  output viu_src_t idx,
  output logic lvl
);
  logic [15:0] hi_req;
  logic [15:0] lo_req;

  assign hi_req = req & high_lvl & {16{allow_high}};
  assign lo_req = req & ~high_lvl & {16{allow_low}};

  // High level first, then lowest index within a level
  always_comb begin
    valid = 1'b0;
    idx = '0;
    lvl = 1'b0;
    for (int i = `VIU_NSRC - 1; i >= 0; i--) begin
      if (lo_req[i]) begin
        valid = 1'b1;
        idx = viu_src_t'(i);
        lvl = 1'b0;
      end
    end
    for (int i = `VIU_NSRC - 1; i >= 0; i--) begin
      if (hi_req[i]) begin
        valid = 1'b1;
        idx = viu_src_t'(i);
        lvl = 1'b1;
      end
    end
  end
endmodule : viu_arbiter
`default_nettype wire

//--- viu_top_sva.sv
// Port-level assertion checker for the vectored interrupt unit
`timescale 1ns/10ps
`default_nettype none
module viu_top_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Core handshake and one event
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [3:0] irq_source,
  input wire logic irq_level,
  input wire logic irq_ack,
  input wire logic timer0_ovf_set
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic [7:0] vec_of(input logic [3:0] s);
    return (s == 4'h0) ? 8'h33 : 8'h03 + {s - 4'h1 + {3'h0, s > 4'h6}, 3'h0};
  endfunction : vec_of
  a_vec_map: assert property (irq_req |-> irq_vector == vec_of(irq_source))
    else $error("offered vector does not match source");
  a_pf_high: assert property (irq_req && irq_source == 4'h0 |-> irq_level)
    else $error("power fail offered at low level");
  a_ack_settle: assert property (irq_req && irq_ack |=> !irq_req ##1 !irq_req)
    else $error("request not withdrawn after acknowledge");
  a_t0_cleared: assert property (irq_req && irq_ack && irq_source == 4'h4 && !timer0_ovf_set ##1
    !timer0_ovf_set [*6] |-> !(irq_req && irq_source == 4'h4))
    else $error("timer0 request offered again after vectoring");
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not given after one wait state");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_decode: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h020))
    else $error("error flag does not match address decode");
  c_grant: cover property (irq_req && irq_ack);
  c_error: cover property (pready && pslverr);
  c_high: cover property (irq_req && irq_level);
endmodule : viu_top_sva
bind viu_top viu_top_sva i_sva (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .irq_req,
  .irq_vector, .irq_source, .irq_level, .irq_ack, .timer0_ovf_set);
`default_nettype wire

//--- viu_core_model.sv
// Behavioural CPU core: takes offered vectors and returns from service
`timescale 1ns/10ps
`default_nettype none
module viu_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Offer from the unit
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [3:0] irq_source,
  // Bench control
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  // Handshake back
  output logic irq_ack,
  output logic irq_return,
  // Record of grants
  output logic [7:0] got_vec,
  output logic [3:0] got_src,
  output logic [7:0] got_cnt
);
  logic [3:0] wait_q;
  logic [1:0] ret_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      ret_q <= 2'h0;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      got_vec <= 8'h00;
      got_src <= 4'h0;
      got_cnt <= 8'h00;
    end else begin
      wait_q <= irq_req ? wait_q + 4'h1 : 4'h0;
      // Only acknowledges a standing offer, after a chosen delay
      irq_ack <= ack_en && irq_req && !irq_ack && wait_q >= ack_wait;
      irq_return <= ret_q == 2'h1;
      if (ret_q != 2'h0) begin
        ret_q <= ret_q - 2'h1;
      end
      if (irq_ack && irq_req) begin
        got_vec <= irq_vector;
        got_src <= irq_source;
        got_cnt <= got_cnt + 8'h01;
        ret_q <= 2'h3;
      end
    end
  end
endmodule : viu_core_model
`default_nettype wire

//--- viu_top_tb.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/10ps
`default_nettype none
module viu_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, err_q, irq_req, irq_level, irq_ack, irq_return;
  logic [7:0] irq_vector, got_vec, got_cnt;
  logic [3:0] irq_source, got_src;
  logic [15:0] ev = 16'h0000;
  logic alt = 1'b0;
  logic ack_en = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  // Enable register byte address and bit per source
  localparam logic [15:0] ENT [16] = '{16'h1820, 16'h0401, 16'h0420, 16'h0440, 16'h0402, 16'h0C01, 16'h0C10,
    16'h0404, 16'h0C02, 16'h0C20, 16'h0408, 16'h0C04, 16'h0C40, 16'h0410, 16'h0C08, 16'h0C80};
  localparam logic [15:0] MSK [7] = '{16'h047F, 16'h087F, 16'h0CFF, 16'h10FF, 16'h147F, 16'h1830, 16'h1C7F};
  always #5 pclk = ~pclk;
  viu_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_pin_n(~{ev[14] & ~alt, ev[11] & ~alt, ev[8] & ~alt, ev[5] & ~alt, ev[7], ev[1]}),
    .power_fail_set(ev[0]), .timer0_ovf_set(ev[4]), .timer1_ovf_set(ev[10]),
    .timer2_ovf_set(ev[15] & ~alt), .timer2_second_set(ev[15] & alt), .compare_set({ev[12], ev[9], ev[6]}),
    .capture_set({ev[14], ev[11], ev[8], ev[5]} & {4{alt}}), .serial0_rx_set(ev[13] & ~alt),
    .serial0_tx_set(ev[13] & alt), .serial1_rx_set(ev[2] & ~alt), .serial1_tx_set(ev[2] & alt),
    .converter_done_set(ev[3]), .irq_req, .irq_vector, .irq_source, .irq_level, .irq_ack, .irq_return);
  viu_core_model i_core (.pclk, .presetn, .irq_req, .irq_vector, .irq_source, .ack_en, .ack_wait,
    .irq_ack, .irq_return, .got_vec, .got_src, .got_cnt);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd_q);
  endtask : rdc
  function automatic logic [7:0] exp_vec(input int s);
    if (s == 0) return 8'h33;
    return 8'h03 + 8'((s - 1 + (s > 6 ? 1 : 0)) * 8);
  endfunction : exp_vec
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    logic [7:0] c;
    logic one;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0000_0000, "timer_ctrl");
    for (int k = 0; k < 7; k++) begin
      rdc({4'h0, MSK[k][15:8]}, 32'h0000_0000, "reset_value");
      apb(1'b1, {4'h0, MSK[k][15:8]}, 32'h0000_00FF);
      rdc({4'h0, MSK[k][15:8]}, {24'h00_0000, MSK[k][7:0]}, "write_mask");
      apb(1'b1, {4'h0, MSK[k][15:8]}, 32'h0000_0000);
    end
    apb(1'b1, 12'h020, 32'h0000_FFFF);
    // Status keeps the last offer: power fail from the watchdog mask test, high level, now withdrawn
    rdc(12'h020, 32'h0000_2033, "status");
    rdc(12'h024, 32'h0000_0000, "unmapped_data");
    chk("unmapped_err", 32'h0000_0001, {31'h0000_0000, err_q});
    $display("test registers done");
    ev <= 16'h0002;
    repeat (5) @(posedge pclk);
    rdc(12'h000, 32'h0000_0002, "ext0_level_low");
    ev <= 16'h0000;
    repeat (5) @(posedge pclk);
    rdc(12'h000, 32'h0000_0000, "ext0_level_high");
    $display("test level mode done");
    apb(1'b1, 12'h000, 32'h0000_0005);
    ack_en <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      alt <= (p == 1);
      for (int s = 0; s < 16; s++) begin
        c = got_cnt;
        ack_wait <= 4'(s % 4);
        apb(1'b1, {4'h0, ENT[s][15:8]}, {24'h00_0000, ENT[s][7:0]});
        @(posedge pclk);
        ev <= 16'h0001 << s;
        @(posedge pclk);
        ev <= 16'h0000;
        repeat (24) @(posedge pclk);
        chk("vector", {24'h00_0000, exp_vec(s)}, {24'h00_0000, got_vec});
        chk("source", 32'(s), {28'h000_0000, got_src});
        one = (s == 1 || s == 4 || s == 7 || s == 10);
        chk("single_grant", 32'(one), 32'(got_cnt - c == 8'h01));
        apb(1'b1, {4'h0, ENT[s][15:8]}, 32'h0000_0000);
        apb(1'b1, 12'h014, 32'h0000_0000);
        apb(1'b1, 12'h01C, 32'h0000_0000);
        apb(1'b1, 12'h018, 32'h0000_0000);
      end
    end
    $display("test vectors done");
    ack_en <= 1'b0;
    apb(1'b1, 12'h004, 32'h0000_0002);
    apb(1'b1, 12'h00C, 32'h0000_0011);
    @(posedge pclk);
    ev <= 16'h0070;
    @(posedge pclk);
    ev <= 16'h0000;
    repeat (4) @(posedge pclk);
    chk("same_level", 32'h0000_0004, {28'h000_0000, irq_source});
    apb(1'b1, 12'h010, 32'h0000_0010);
    repeat (2) @(posedge pclk);
    chk("high_level", 32'h0000_0006, {28'h000_0000, irq_source});
    chk("level_flag", 32'h0000_0001, {31'h0000_0000, irq_level});
    $display("test priority done");
    test_done();
  end
endmodule : viu_top_tb
`default_nettype wire
